// file: src/vfc_pkg.sv
// Package: register map, field positions and reset values of the VLAN frame check policy
package vfc_pkg;

    // ---------------------------------------------------------------
    // Register indices and byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] MGMT_CHK_IDX = 8'h02;
    localparam logic [7:0] UNTAG_DROP_IDX = 8'h03;
    localparam logic [7:0] MEMB_DTAG_IDX = 8'h05;
    localparam int ADDR_W = 12;
    localparam logic [11:0] MGMT_CHK_ADDR = {2'b00, MGMT_CHK_IDX, 2'b00};
    localparam logic [11:0] UNTAG_DROP_ADDR = {2'b00, UNTAG_DROP_IDX, 2'b00};
    localparam logic [11:0] MEMB_DTAG_ADDR = {2'b00, MEMB_DTAG_IDX, 2'b00};

    // ---------------------------------------------------------------
    // Reset values and writable masks
    // ---------------------------------------------------------------
    localparam logic [7:0] MGMT_CHK_RST = 8'h10;
    localparam logic [15:0] UNTAG_DROP_RST = 16'h0000;
    localparam logic [15:0] UNTAG_DROP_MASK = 16'h01ff;
    localparam logic [7:0] MEMB_DTAG_RST = 8'hc0;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int GXRP_UNTAG_BIT = 6;
    localparam int GXRP_FWD_BIT = 5;
    localparam int HOST_FWD_BYPASS_BIT = 2;
    localparam int SRC_MEMB_LSB = 6;
    localparam int GVRP_TO_MGMT_BIT = 5;
    localparam int GMRP_TO_MGMT_BIT = 4;
    localparam int DTAG_MODE_LSB = 2;
    localparam int RSV_FLOOD_BIT = 1;

    // ---------------------------------------------------------------
    // Ports and codes
    // ---------------------------------------------------------------
    localparam logic [3:0] HOST_PORT = 4'h8;
    localparam logic [3:0] WAN_PORT = 4'h5;
    localparam logic [1:0] DUAL_MGMT_SEL = 2'b11;
    localparam logic [1:0] DTAG_MODE_OFF = 2'b00;
    localparam logic [1:0] DTAG_MODE_ON = 2'b01;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [39:0] RSV_MCAST_PREFIX = 40'h0180c20000;
    localparam logic [7:0] RSV_MCAST_LOW = 8'h02;
    localparam logic [7:0] RSV_MCAST_HIGH = 8'h2f;

    // Action on a failed source-membership check
    typedef enum logic [1:0] {
        VFC_SM_FWD_NOLEARN = 2'b00,
        VFC_SM_DROP = 2'b01,
        VFC_SM_FWD_LEARN = 2'b10,
        VFC_SM_MGMT_ONLY = 2'b11
    } vfc_sm_action_t;

endpackage

// file: src/vfc_axil_slave.sv
// AXI4-Lite slave front end that turns bus beats into register strobes
`timescale 1ns/1ps
`default_nettype none
module vfc_axil_slave #(
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic [AW-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);

    logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic aw_take, w_take, ar_take;

    // Address and data may come in either order; each is held until the write response is accepted
    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready = ~w_have_q;
    assign s_axi_arready = ~rvalid_q;
    assign aw_take = s_axi_awvalid & ~aw_have_q;
    assign w_take = s_axi_wvalid & ~w_have_q;
    assign ar_take = s_axi_arvalid & ~rvalid_q;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign wr_en = aw_have_q & w_have_q & ~bvalid_q;
    assign rd_addr = s_axi_araddr;

    // Next state of both channels
    always_comb begin
        aw_have_d = aw_have_q | aw_take;
        w_have_d = w_have_q | w_take;
        awaddr_d = aw_take ? s_axi_awaddr : awaddr_q;
        wdata_d = w_take ? s_axi_wdata : wdata_q;
        wstrb_d = w_take ? s_axi_wstrb : wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (wr_en) begin
            bvalid_d = 1'b1;
            bresp_d = wr_err ? vfc_pkg::RESP_SLVERR : vfc_pkg::RESP_OKAY;
        end else if (bvalid_q & s_axi_bready) begin
            bvalid_d = 1'b0;
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
        end
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = rd_err ? vfc_pkg::RESP_SLVERR : vfc_pkg::RESP_OKAY;
        end else if (rvalid_q & s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // Channel state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rresp_q <= 2'b00;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wstrb_q <= wstrb_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

// file: src/vfc_frame_decide.sv
// Combinational frame check decision from descriptor fields and control registers
`timescale 1ns/1ps
`default_nettype none
module vfc_frame_decide (
    // Frame descriptor
    input wire logic [3:0] src_port,
    input wire logic [47:0] dst_mac,
    input wire logic is_gmrp,
    input wire logic is_gvrp,
    input wire logic has_1q_tag,
    input wire logic vid_hit,
    input wire logic src_member,
    // Switch context
    input wire logic q_enable,
    input wire logic mgmt_mode,
    input wire logic [1:0] mgmt_port_select,
    // Control registers
    input wire logic [7:0] mgmt_chk,
    input wire logic [15:0] untag_drop,
    input wire logic [7:0] memb_dtag,
    // Decisions
    output logic chk_untag_map,
    output logic chk_fwd_map,
    output logic drop,
    output logic learn,
    output logic to_mgmt,
    output logic mgmt_only,
    output logic rsv_flood,
    output logic dt_active
);

    logic host, gxrp, vlan_on, rsv, member_fail, drop_untag, rsv_trap;
    logic [1:0] sm_mode;

    // Port 5 counts as a management port only in dual mode
    always_comb begin
        host = (src_port == vfc_pkg::HOST_PORT) ||
               ((mgmt_port_select == vfc_pkg::DUAL_MGMT_SEL) && (src_port == vfc_pkg::WAN_PORT));
        gxrp = is_gmrp | is_gvrp;
        dt_active = memb_dtag[vfc_pkg::DTAG_MODE_LSB +: 2] == vfc_pkg::DTAG_MODE_ON;
        vlan_on = q_enable | dt_active;
        chk_untag_map = gxrp & mgmt_chk[vfc_pkg::GXRP_UNTAG_BIT] & ~host;
        chk_fwd_map = vlan_on & ((gxrp & mgmt_chk[vfc_pkg::GXRP_FWD_BIT] & ~host) |
                      (host & ~mgmt_chk[vfc_pkg::HOST_FWD_BYPASS_BIT]));
        // Only data ports index the field; bit 8 is never applied
        drop_untag = ~has_1q_tag & ~host & (src_port < 4'h6) & untag_drop[src_port];
        member_fail = vid_hit & ~src_member & ~host;
        sm_mode = memb_dtag[vfc_pkg::SRC_MEMB_LSB +: 2];
        rsv = (dst_mac[47:8] == vfc_pkg::RSV_MCAST_PREFIX) && ((dst_mac[7:0] == 8'h00) ||
              ((dst_mac[7:0] >= vfc_pkg::RSV_MCAST_LOW) && (dst_mac[7:0] <= vfc_pkg::RSV_MCAST_HIGH)));
        rsv_flood = dt_active & mgmt_mode & rsv & memb_dtag[vfc_pkg::RSV_FLOOD_BIT];
        rsv_trap = dt_active & mgmt_mode & rsv & ~memb_dtag[vfc_pkg::RSV_FLOOD_BIT];
        drop = drop_untag | (member_fail & (sm_mode == vfc_pkg::VFC_SM_DROP));
        learn = ~member_fail | (sm_mode == vfc_pkg::VFC_SM_FWD_LEARN);
        mgmt_only = ~drop & ((member_fail & (sm_mode == vfc_pkg::VFC_SM_MGMT_ONLY)) | rsv_trap);
        to_mgmt = ~drop & (mgmt_only | (is_gvrp & memb_dtag[vfc_pkg::GVRP_TO_MGMT_BIT]) |
                  (is_gmrp & memb_dtag[vfc_pkg::GMRP_TO_MGMT_BIT]));
    end

endmodule
`default_nettype wire

// file: src/vfc_top.sv
// Top of the VLAN frame check policy: register file, bus slave and registered decisions
//
// Function
// - GMRP/GVRP untag-map check when bit six set
// - GMRP/GVRP forward-map check when bit five set and VLAN or double tagging on
// - Bit two exempts host frames from forward check
// - Drop untagged frames on ports marked in field
// - Field bits five..zero map ports, bit eight host; bit eight is stored but never applied
// - Host port, dual-mode port five, never drop-untagged
// - Source member only if listed in VLAN entry
// - Membership failure action chosen by field seven:six
// - No membership check on host management ports
// - Bit five sends GVRP frames to management
// - Bit four sends GMRP frames to management
// - Double tagging off at 00, on at 01
// - Reserved multicast flooded or trapped by bit one when double tagging on in management mode
`timescale 1ns/1ps
`default_nettype none
module vfc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,

    // AXI4-Lite register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,

    // Switch context
    input wire logic q_enable,
    input wire logic mgmt_mode,
    input wire logic [1:0] mgmt_port_select,

    // Frame descriptor from the parser
    input wire logic frm_valid,
    input wire logic [3:0] frm_src_port,
    input wire logic [47:0] frm_dst_mac,
    input wire logic frm_is_gmrp,
    input wire logic frm_is_gvrp,
    input wire logic frm_has_1q_tag,
    input wire logic frm_vid_hit,
    input wire logic frm_src_member,

    // Decision to the forwarding pipeline
    output logic dec_valid,
    output logic dec_chk_untag_map,
    output logic dec_chk_fwd_map,
    output logic dec_drop,
    output logic dec_learn,
    output logic dec_to_mgmt,
    output logic dec_mgmt_only,
    output logic dec_rsv_flood,
    output logic dec_dt_active
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    // Control registers
    logic [7:0] mgmt_chk_q;
    logic [7:0] mgmt_chk_d;
    logic [15:0] untag_drop_q;
    logic [15:0] untag_drop_d;
    logic [7:0] memb_dtag_q;
    logic [7:0] memb_dtag_d;

    // Slave strobes
    logic wr_en;
    logic wr_err;
    logic rd_err;
    logic [11:0] wr_addr;
    logic [11:0] rd_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic [3:0] wr_strb;

    // Raw decisions
    logic c_untag;
    logic c_fwd;
    logic c_drop;
    logic c_learn;
    logic c_to_mgmt;
    logic c_mgmt_only;
    logic c_flood;
    logic c_dt;

    // Decision register
    logic [8:0] dec_d;
    logic [8:0] dec_q;

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    vfc_axil_slave #(
        .AW(vfc_pkg::ADDR_W)
    ) u_slave (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    // Unmapped words answer with an error and never touch state
    always_comb begin
        wr_err = !((wr_addr == vfc_pkg::MGMT_CHK_ADDR) ||
                   (wr_addr == vfc_pkg::UNTAG_DROP_ADDR) ||
                   (wr_addr == vfc_pkg::MEMB_DTAG_ADDR));
        rd_err = !((rd_addr == vfc_pkg::MGMT_CHK_ADDR) ||
                   (rd_addr == vfc_pkg::UNTAG_DROP_ADDR) ||
                   (rd_addr == vfc_pkg::MEMB_DTAG_ADDR));
    end

    // Byte-lane writes; reserved bits store what software writes, bits 15:9 stay zero
    always_comb begin
        mgmt_chk_d = mgmt_chk_q;
        untag_drop_d = untag_drop_q;
        memb_dtag_d = memb_dtag_q;
        if (wr_en) begin
            if ((wr_addr == vfc_pkg::MGMT_CHK_ADDR) && wr_strb[0]) begin
                mgmt_chk_d = wr_data[7:0];
            end
            if (wr_addr == vfc_pkg::UNTAG_DROP_ADDR) begin
                if (wr_strb[0]) begin
                    untag_drop_d[7:0] = wr_data[7:0];
                end
                if (wr_strb[1]) begin
                    untag_drop_d[15:8] = wr_data[15:8] & vfc_pkg::UNTAG_DROP_MASK[15:8];
                end
            end
            // Reserved mode codes are stored but act as double tagging off
            if ((wr_addr == vfc_pkg::MEMB_DTAG_ADDR) && wr_strb[0]) begin
                memb_dtag_d = wr_data[7:0];
            end
        end
    end

    // Register state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mgmt_chk_q <= vfc_pkg::MGMT_CHK_RST;
            untag_drop_q <= vfc_pkg::UNTAG_DROP_RST;
            memb_dtag_q <= vfc_pkg::MEMB_DTAG_RST;
        end else begin
            mgmt_chk_q <= mgmt_chk_d;
            untag_drop_q <= untag_drop_d;
            memb_dtag_q <= memb_dtag_d;
        end
    end

    // Read mux; the slave registers the result
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_addr == vfc_pkg::MGMT_CHK_ADDR) begin
            rd_data[7:0] = mgmt_chk_q;
        end else if (rd_addr == vfc_pkg::UNTAG_DROP_ADDR) begin
            rd_data[15:0] = untag_drop_q;
        end else if (rd_addr == vfc_pkg::MEMB_DTAG_ADDR) begin
            rd_data[7:0] = memb_dtag_q;
        end
    end

    // ---------------------------------------------------------------
    // Frame decision
    // ---------------------------------------------------------------
    vfc_frame_decide u_decide (
        .src_port(frm_src_port),
        .dst_mac(frm_dst_mac),
        .is_gmrp(frm_is_gmrp),
        .is_gvrp(frm_is_gvrp),
        .has_1q_tag(frm_has_1q_tag),
        .vid_hit(frm_vid_hit),
        .src_member(frm_src_member),
        .q_enable(q_enable),
        .mgmt_mode(mgmt_mode),
        .mgmt_port_select(mgmt_port_select),
        .mgmt_chk(mgmt_chk_q),
        .untag_drop(untag_drop_q),
        .memb_dtag(memb_dtag_q),
        .chk_untag_map(c_untag),
        .chk_fwd_map(c_fwd),
        .drop(c_drop),
        .learn(c_learn),
        .to_mgmt(c_to_mgmt),
        .mgmt_only(c_mgmt_only),
        .rsv_flood(c_flood),
        .dt_active(c_dt)
    );

    // Decisions are held between frames so the pipeline may sample late
    always_comb begin
        dec_d[8] = frm_valid;
        dec_d[7:0] = dec_q[7:0];
        if (frm_valid) begin
            dec_d[7:0] = {
                c_untag,
                c_fwd,
                c_drop,
                c_learn,
                c_to_mgmt,
                c_mgmt_only,
                c_flood,
                c_dt
            };
        end
    end

    // Output register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_q <= 9'h000;
        end else begin
            dec_q <= dec_d;
        end
    end

    assign dec_valid = dec_q[8];
    assign dec_chk_untag_map = dec_q[7];
    assign dec_chk_fwd_map = dec_q[6];
    assign dec_drop = dec_q[5];
    assign dec_learn = dec_q[4];
    assign dec_to_mgmt = dec_q[3];
    assign dec_mgmt_only = dec_q[2];
    assign dec_rsv_flood = dec_q[1];
    assign dec_dt_active = dec_q[0];

endmodule
`default_nettype wire

// file: tb/vfc_monitor.sv
// Port checker for the VLAN frame check policy top
`timescale 1ns/1ps
`default_nettype none
module vfc_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Frame side
    input wire logic mgmt_mode,
    input wire logic [1:0] mgmt_port_select,
    input wire logic frm_valid,
    input wire logic [3:0] frm_src_port,
    input wire logic frm_is_gmrp,
    input wire logic frm_is_gvrp,
    input wire logic frm_has_1q_tag,
    input wire logic frm_vid_hit,
    input wire logic frm_src_member,
    // Decisions
    input wire logic dec_valid,
    input wire logic dec_chk_untag_map,
    input wire logic dec_chk_fwd_map,
    input wire logic dec_drop,
    input wire logic dec_learn,
    input wire logic dec_to_mgmt,
    input wire logic dec_mgmt_only,
    input wire logic dec_rsv_flood,
    input wire logic dec_dt_active
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Host means port 8, or port 5 in dual management mode
    wire logic host = frm_src_port == 4'h8 || (frm_src_port == 4'h5 && mgmt_port_select == 2'b11);
    wire logic gx = frm_is_gmrp || frm_is_gvrp;
    AST_DEC_LAT: assert property (frm_valid |=> dec_valid) else $error("decision late");
    AST_DEC_ONE: assert property (!frm_valid |=> !dec_valid) else $error("decision without frame");
    AST_DEC_HOLD: assert property (!frm_valid |=> $stable({dec_drop, dec_learn, dec_to_mgmt, dec_dt_active}))
        else $error("decision bits moved");
    AST_HOST_EXEMPT: assert property (frm_valid && host |=> !dec_drop && dec_learn && !dec_chk_untag_map)
        else $error("host frame not exempt");
    AST_UNTAG_GXRP: assert property (frm_valid && !gx |=> !dec_chk_untag_map)
        else $error("untag check on plain frame");
    AST_FWD_DATA: assert property (frm_valid && !gx && !host |=> !dec_chk_fwd_map)
        else $error("forward check on plain data frame");
    AST_TAG_KEEP: assert property (frm_valid && frm_has_1q_tag && (!frm_vid_hit || frm_src_member)
        |=> !dec_drop && dec_learn) else $error("tagged member frame dropped");
    AST_DROP_EXCL: assert property (dec_drop |-> !dec_to_mgmt && !dec_mgmt_only)
        else $error("dropped frame sent to management");
    AST_FLOOD_CTX: assert property (frm_valid && !mgmt_mode |=> !dec_rsv_flood)
        else $error("flood outside management mode");
    AST_FLOOD_DT: assert property (dec_rsv_flood |-> dec_dt_active) else $error("flood without dt");
    AST_RD_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    AST_WR_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write response late");
    // Main scenarios
    cover property (frm_valid && host);
    cover property (dec_drop);
    cover property (dec_rsv_flood);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind vfc_top vfc_monitor u_mon (.*);
`default_nettype wire

// file: tb/vlan_frame_check_policy_test.sv
// Self-checking bench for the VLAN frame check policy
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module vlan_frame_check_policy_test;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [3:0] s_axi_wstrb, frm_src_port;
    logic [1:0] s_axi_bresp, s_axi_rresp, mgmt_port_select, eb;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, q_enable, mgmt_mode;
    logic frm_valid, frm_is_gmrp, frm_is_gvrp, frm_has_1q_tag, frm_vid_hit, frm_src_member;
    logic [47:0] frm_dst_mac;
    logic dec_valid, dec_chk_untag_map, dec_chk_fwd_map, dec_drop, dec_learn, dec_to_mgmt;
    logic dec_mgmt_only, dec_rsv_flood, dec_dt_active;
    wire logic [7:0] dec_bits = {dec_chk_untag_map, dec_chk_fwd_map, dec_drop, dec_learn, dec_to_mgmt,
        dec_mgmt_only, dec_rsv_flood, dec_dt_active};
    logic [31:0] seed = 32'h00000b1f;
    logic [7:0] r2, r5, ed;
    logic [15:0] r3;
    logic [33:0] er;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [7:0] exp_d[$];
    int error_cnt = 0, cmp_count = 0, cyc = 0;

    vfc_top DUT (.*);

    // ---------------------------------------------------------------
    // Clock, stimulus helpers
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Write beat pair, bready held until the response lands
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        exp_b.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask

    task automatic axr(input logic [11:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask

    // Back-to-back random frames; expectation from the shadow registers
    task automatic send_frames(input int n);
        logic [3:0] p;
        logic [47:0] da;
        logic [1:0] m;
        logic host, gx, dt, von, du, fail, dr, rsv, trap, mo;
        for (int i = 0; i < n; i++) begin
            r = rnd();
            p = (r[2:0] > 3'h5) ? 4'h8 : {1'b0, r[2:0]};
            m = r5[7:6];
            da = {vfc_pkg::RSV_MCAST_PREFIX ^ {r[11], 39'h0}, 2'b00, r[10:5]};
            host = p == 4'h8 || (p == 4'h5 && r[4:3] == vfc_pkg::DUAL_MGMT_SEL);
            gx = r[12] || r[13];
            dt = r5[3:2] == vfc_pkg::DTAG_MODE_ON;
            von = r[16] || dt;
            du = !r[14] && !host && p < 4'h6 && r3[p];
            fail = r[15] && !r[17] && !host;
            dr = du || (fail && m == 2'b01);
            rsv = !r[11] && (da[7:0] == 8'h00 || (da[7:0] >= 8'h02 && da[7:0] <= 8'h2f));
            trap = dt && r[18] && rsv && !r5[1];
            mo = !dr && ((fail && m == 2'b11) || trap);
            exp_d.push_back({gx && r2[6] && !host, von && ((gx && r2[5] && !host) || (host && !r2[2])), dr,
                !fail || m == 2'b10, !dr && (mo || (r[13] && r5[5]) || (r[12] && r5[4])), mo,
                dt && r[18] && rsv && r5[1], dt});
            frm_valid <= 1'b1;
            frm_src_port <= p;
            frm_dst_mac <= da;
            frm_is_gmrp <= r[12];
            frm_is_gvrp <= r[13];
            frm_has_1q_tag <= r[14];
            frm_vid_hit <= r[15];
            frm_src_member <= r[17];
            q_enable <= r[16];
            mgmt_mode <= r[18];
            mgmt_port_select <= r[4:3];
            @(posedge clk);
        end
        frm_valid <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Output watcher and hang guard
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
        if (!rst && s_axi_rvalid && s_axi_rready) begin
            er = exp_r.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, er)
        end
        if (!rst && s_axi_bvalid && s_axi_bready) begin
            eb = exp_b.pop_front();
            `CHK(s_axi_bresp, eb)
        end
        if (!rst && dec_valid) begin
            ed = exp_d.pop_front();
            `CHK(dec_bits, ed)
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hf};
        {q_enable, mgmt_mode, mgmt_port_select, frm_valid, frm_src_port, frm_dst_mac} = 57'h0;
        {frm_is_gmrp, frm_is_gvrp, frm_has_1q_tag, frm_vid_hit, frm_src_member} = 5'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped place and the read-only upper drop bits
        axr(vfc_pkg::MGMT_CHK_ADDR, {vfc_pkg::RESP_OKAY, 32'h00000010});
        axr(vfc_pkg::MEMB_DTAG_ADDR, {vfc_pkg::RESP_OKAY, 32'h000000c0});
        axw(12'h010, 32'hffffffff, vfc_pkg::RESP_SLVERR);
        axr(12'h010, {vfc_pkg::RESP_SLVERR, 32'h0});
        axw(vfc_pkg::UNTAG_DROP_ADDR, 32'hffffffff, vfc_pkg::RESP_OKAY);
        axr(vfc_pkg::UNTAG_DROP_ADDR, {vfc_pkg::RESP_OKAY, 32'h000001ff});
        // Every membership action with both mode codes, random remaining bits
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            r2 = (r[7:0] & 8'h64) | 8'h10;
            r3 = {7'h00, r[16:8]};
            r5 = {i[1:0], r[21:20], 1'b0, i[2], r[22], 1'b0};
            axw(vfc_pkg::MGMT_CHK_ADDR, {24'h0, r2}, vfc_pkg::RESP_OKAY);
            axw(vfc_pkg::UNTAG_DROP_ADDR, {16'h0, r3}, vfc_pkg::RESP_OKAY);
            axw(vfc_pkg::MEMB_DTAG_ADDR, {24'h0, r5}, vfc_pkg::RESP_OKAY);
            axr(vfc_pkg::MEMB_DTAG_ADDR, {vfc_pkg::RESP_OKAY, 24'h0, r5});
            send_frames(12);
        end
        repeat (3) @(posedge clk);
        `CHK(exp_d.size() + exp_r.size() + exp_b.size(), 0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
